// file: memory_map_and_config.sv
// Purpose: Address decode, stack engine, vectors and configuration of an 8-bit controller.
// Assumes: One clock pclk, asynchronous active-low presetn, APB register access.
// Notes:   The CPU holds off its memory port while stack_busy is high.
//
// The APB slave port and the placing of the registers are this design's own decisions.
module memory_map_and_config
  import memory_map_pkg::*;
(
  input  wire logic        pclk,             // System clock.
  input  wire logic        presetn,          // Reset, active low.
  input  wire logic [11:0] paddr,            // APB byte address.
  input  wire logic        psel,             // APB select.
  input  wire logic        penable,          // APB access phase.
  input  wire logic        pwrite,           // APB write.
  input  wire logic [31:0] pwdata,           // APB write data.
  output logic      [31:0] prdata,           // APB read data.
  output logic             pready,           // APB ready.
  output logic             pslverr,          // APB error.
  input  wire logic [15:0] cpu_addr,         // CPU memory address.
  input  wire logic        cpu_rd,           // CPU read strobe.
  input  wire logic        cpu_wr,           // CPU write strobe.
  input  wire logic [7:0]  cpu_wdata,        // CPU write data.
  output logic      [7:0]  cpu_rdata,        // CPU read data.
  input  wire logic        stk_push,         // Push one byte.
  input  wire logic [7:0]  stk_push_data,    // Byte to push.
  input  wire logic        stk_pull,         // Pull one byte.
  output logic      [7:0]  stk_pull_data,    // Pulled byte.
  input  wire logic        sp_load,          // Load stack pointer.
  input  wire logic [15:0] sp_load_value,    // New stack pointer.
  output logic      [15:0] stack_pointer,    // Current stack pointer.
  input  wire logic        int_entry,        // Start interrupt stacking.
  input  wire cpu_ctx_s    int_ctx,          // State to stack.
  input  wire logic        call_entry,       // Start call stacking.
  input  wire logic [15:0] call_return,      // Return address of the call.
  output logic             stack_busy,       // Stack engine writing.
  input  wire logic [VEC_SOURCES:1] irq_pending, // Pending sources, 1 is highest.
  input  wire logic        software_interrupt, // Software interrupt request.
  output vector_s          int_vector,       // Chosen vector.
  input  wire logic        stop_opcode,      // Stop opcode decoded.
  input  wire logic        stop_wake,        // Wake event leaving stop mode.
  output logic             illegal_opcode,   // Stop refused, one-cycle pulse.
  output logic             stop_mode,        // Device in stop mode.
  output logic             oscillator_run_enable, // Crystal oscillator enable.
  output logic             rc_clock_run,     // Internal RC clock enable.
  output logic             operating_watchdog, // Watchdog running.
  output logic             usb_regulator_enable, // USB regulator on.
  input  wire logic        usb_bus_reset,    // USB bus reset, async.
  input  wire logic        usb_irq_ack,      // Clears USB request.
  output logic             usb_reset_irq,    // USB reset interrupt request.
  output logic             chip_reset_req,   // Chip reset request pulse.
  output logic             flash_busy        // Page erase in progress.
);

  localparam int RAM_AW  = $clog2(RAM_BYTES);
  localparam int USER_AW = $clog2(USER_BYTES);
  localparam int OPT_IDX = 0;

  logic [7:0] ram_mem [RAM_BYTES];
  logic [7:0] user_mem [USER_BYTES];
  logic [7:0] vec_mem [VEC_BYTES + 1];

  logic [7:0]   cfg1_ff;
  logic [7:0]   cfg2_ff;
  logic [15:0]  sp_ff;
  logic [15:0]  nxt_sp;
  stack_state_e st_ff;
  logic [7:0]   push_q_ff [INT_STACK_BYTES];
  logic [2:0]   push_idx_ff;
  logic [2:0]   push_left_ff;
  logic         push_we;
  logic [7:0]   push_byte;
  logic         erase_busy_ff;
  logic [8:0]   erase_cnt_ff;
  logic [USER_AW-1:0] erase_base_ff;
  logic [2:0]   usb_sync_ff;
  logic         usb_level_ff;
  logic         usb_event;
  logic         stop_ff;
  logic         apb_wr;
  logic         apb_setup;
  logic         addr_ok;
  logic [31:0]  nxt_prdata;
  logic [15:0]  prog_addr;
  logic [15:0]  erase_addr;
  logic         prog_ok;
  logic         erase_ok;
  logic [15:0]  vec_pick;

  function automatic logic in_ram(input logic [15:0] a);
    return (a >= RAM_FIRST) && (a <= RAM_LAST);
  endfunction

  function automatic logic [RAM_AW-1:0] ram_idx(input logic [15:0] a);
    return RAM_AW'(a - RAM_FIRST);
  endfunction

  function automatic logic in_user(input logic [15:0] a);
    return (a >= USER_FIRST) && (a <= USER_LAST);
  endfunction

  function automatic logic [USER_AW-1:0] user_idx(input logic [15:0] a);
    return USER_AW'(a - USER_FIRST);
  endfunction

  function automatic logic in_vec(input logic [15:0] a);
    return (a >= OPTION_ADDR) && (a <= VEC_LAST);
  endfunction

  function automatic logic [5:0] vec_idx(input logic [15:0] a);
    return 6'(a - OPTION_ADDR);
  endfunction

  function automatic logic [7:0] mem_read(input logic [15:0] a);
    return in_ram(a) ? ram_mem[ram_idx(a)] : in_user(a) ? user_mem[user_idx(a)]
         : in_vec(a) ? vec_mem[vec_idx(a)] : 8'h00;
  endfunction

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign prog_addr  = pwdata[15:0];
  assign erase_addr = pwdata[15:0];
  assign prog_ok  = in_user(prog_addr) || in_vec(prog_addr);
  assign erase_ok = in_user(erase_addr) || (erase_addr >= VEC_PAGE_FIRST);

  always_comb
  begin
    addr_ok = 1'b1;
    case (paddr)
      OFS_CONFIG_ONE, OFS_CONFIG_TWO, OFS_STACK_PTR, OFS_STATUS: addr_ok = 1'b1;
      OFS_FLASH_PROG:  addr_ok = !pwrite || (prog_ok && !erase_busy_ff);
      OFS_FLASH_ERASE: addr_ok = !pwrite || (erase_ok && !erase_busy_ff);
      default:         addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      OFS_CONFIG_ONE: nxt_prdata[7:0] = cfg1_ff;
      OFS_CONFIG_TWO: nxt_prdata[7:0] = cfg2_ff;
      OFS_STACK_PTR:  nxt_prdata[15:0] = sp_ff;
      OFS_STATUS:     nxt_prdata[3:0] = {usb_reset_irq, stop_ff, erase_busy_ff, stack_busy};
      default:        nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (apb_setup)
    begin
      prdata <= nxt_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg1_ff <= CFG1_RESET;
      cfg2_ff <= CFG2_RESET;
    end
    else if (apb_wr && paddr == OFS_CONFIG_ONE)
    begin
      cfg1_ff <= pwdata[7:0];
    end
    else if (apb_wr && paddr == OFS_CONFIG_TWO)
    begin
      cfg2_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff        <= ST_IDLE;
      push_idx_ff  <= 3'h0;
      push_left_ff <= 3'h0;
      for (int i = 0; i < INT_STACK_BYTES; i++)
      begin
        push_q_ff[i] <= 8'h00;
      end
    end
    else
    begin
      case (st_ff)
        ST_IDLE:
        begin
          if (int_entry)
          begin
            {push_q_ff[1], push_q_ff[0], push_q_ff[2], push_q_ff[3], push_q_ff[4]} <= int_ctx;
            push_idx_ff  <= 3'h0;
            push_left_ff <= 3'(INT_STACK_BYTES);
            st_ff        <= ST_PUSH;
          end
          else if (call_entry)
          begin
            push_q_ff[0] <= call_return[7:0];
            push_q_ff[1] <= call_return[15:8];
            push_idx_ff  <= 3'h0;
            push_left_ff <= 3'(CALL_STACK_BYTES);
            st_ff        <= ST_PUSH;
          end
        end
        ST_PUSH:
        begin
          push_idx_ff  <= push_idx_ff + 3'h1;
          push_left_ff <= push_left_ff - 3'h1;
          if (push_left_ff == 3'h1)
          begin
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  assign stack_busy = (st_ff == ST_PUSH);
  assign push_byte  = stack_busy ? push_q_ff[push_idx_ff] : stk_push_data;
  assign push_we    = stack_busy || (st_ff == ST_IDLE && stk_push && !int_entry
                                     && !call_entry);

  always_comb
  begin
    nxt_sp = sp_ff;
    if (push_we)
    begin
      nxt_sp = sp_ff - 16'h0001;
    end
    else if (stk_pull && !stack_busy)
    begin
      nxt_sp = sp_ff + 16'h0001;
    end
    else if (sp_load && !stack_busy)
    begin
      nxt_sp = sp_load_value;
    end
    else if (apb_wr && paddr == OFS_STACK_PTR)
    begin
      nxt_sp = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_ff <= SP_RESET;
    end
    else
    begin
      sp_ff <= nxt_sp;
    end
  end

  assign stack_pointer = sp_ff;

  always_ff @(posedge pclk)
  begin
    if (push_we && in_ram(sp_ff))
    begin
      ram_mem[ram_idx(sp_ff)] <= push_byte;
    end
    else if (cpu_wr && !stack_busy && in_ram(cpu_addr))
    begin
      ram_mem[ram_idx(cpu_addr)] <= cpu_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_rdata     <= 8'h00;
      stk_pull_data <= 8'h00;
    end
    else
    begin
      if (cpu_rd)
      begin
        cpu_rdata <= mem_read(cpu_addr);
      end
      if (stk_pull && !stack_busy)
      begin
        stk_pull_data <= mem_read(sp_ff + 16'h0001);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      erase_busy_ff <= 1'b0;
      erase_cnt_ff  <= 9'h000;
      erase_base_ff <= '0;
    end
    else if (erase_busy_ff)
    begin
      erase_cnt_ff <= erase_cnt_ff + 9'h001;
      if (erase_cnt_ff == 9'(PAGE_BYTES - 1))
      begin
        erase_busy_ff <= 1'b0;
      end
    end
    else if (apb_wr && paddr == OFS_FLASH_ERASE && erase_ok && in_user(erase_addr))
    begin
      erase_busy_ff <= 1'b1;
      erase_cnt_ff  <= 9'h000;
      erase_base_ff <= user_idx(erase_addr) & ~USER_AW'(PAGE_BYTES - 1);
    end
  end

  assign flash_busy = erase_busy_ff;

  always_ff @(posedge pclk)
  begin
    if (erase_busy_ff)
    begin
      user_mem[erase_base_ff | USER_AW'(erase_cnt_ff)] <= ERASED_BYTE;
    end
    else if (apb_wr && paddr == OFS_FLASH_PROG && in_user(prog_addr))
    begin
      user_mem[user_idx(prog_addr)] <= user_mem[user_idx(prog_addr)] & pwdata[23:16];
    end
  end

  always_ff @(posedge pclk)
  begin
    if (apb_wr && paddr == OFS_FLASH_ERASE && !erase_busy_ff
        && erase_addr >= VEC_PAGE_FIRST)
    begin
      for (int i = OPT_IDX; i <= VEC_BYTES; i++)
      begin
        vec_mem[i] <= ERASED_BYTE;
      end
    end
    else if (apb_wr && paddr == OFS_FLASH_PROG && !erase_busy_ff && in_vec(prog_addr))
    begin
      vec_mem[vec_idx(prog_addr)] <= vec_mem[vec_idx(prog_addr)] & pwdata[23:16];
    end
  end

  always_comb
  begin
    vec_pick = VEC_RESET;
    for (int n = VEC_SOURCES; n >= 1; n--)
    begin
      if (irq_pending[n])
      begin
        vec_pick = VEC_SRC_BASE - 16'(2 * n);
      end
    end
    if (software_interrupt)
    begin
      vec_pick = VEC_SWI;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_vector <= '{valid: 1'b0, addr: VEC_RESET, word: 16'h0000};
    end
    else
    begin
      int_vector.valid <= software_interrupt || (|irq_pending);
      int_vector.addr  <= vec_pick;
      int_vector.word  <= {vec_mem[vec_idx(vec_pick)], vec_mem[vec_idx(vec_pick + 16'h0001)]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_ff        <= 1'b0;
      illegal_opcode <= 1'b0;
    end
    else
    begin
      illegal_opcode <= stop_opcode && !cfg1_ff[CFG1_STOP_ENABLE];
      if (stop_opcode && cfg1_ff[CFG1_STOP_ENABLE])
      begin
        stop_ff <= 1'b1;
      end
      else if (stop_wake)
      begin
        stop_ff <= 1'b0;
      end
    end
  end

  assign stop_mode = stop_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oscillator_run_enable <= 1'b1;
      rc_clock_run          <= 1'b1;
      operating_watchdog    <= 1'b0;
      usb_regulator_enable  <= 1'b0;
    end
    else
    begin
      oscillator_run_enable <= !stop_ff || cfg2_ff[CFG2_XTAL_STOP_RUN];
      rc_clock_run          <= !stop_ff || cfg2_ff[CFG2_RC_STOP_RUN];
      operating_watchdog    <= !cfg1_ff[CFG1_WDOG_DISABLE];
      usb_regulator_enable  <= !cfg2_ff[CFG2_USB_REG_DIS];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      usb_sync_ff  <= 3'h0;
      usb_level_ff <= 1'b0;
    end
    else
    begin
      usb_sync_ff <= {usb_sync_ff[1:0], usb_bus_reset};
      if (usb_sync_ff[1] == usb_sync_ff[2])
      begin
        usb_level_ff <= usb_sync_ff[2];
      end
    end
  end

  assign usb_event = usb_sync_ff[1] && usb_sync_ff[2] && !usb_level_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      usb_reset_irq  <= 1'b0;
      chip_reset_req <= 1'b0;
    end
    else
    begin
      chip_reset_req <= usb_event && !cfg2_ff[CFG2_USB_RST_IRQ];
      if (usb_event && cfg2_ff[CFG2_USB_RST_IRQ])
      begin
        usb_reset_irq <= 1'b1;
      end
      else if (usb_irq_ack)
      begin
        usb_reset_irq <= 1'b0;
      end
    end
  end

endmodule

// file: memory_map_pkg.sv
// Purpose: Shared constants and types for the memory map and configuration block.
// Assumes: 16-bit CPU address space, 8-bit data, APB register port with 32-bit data.
// Notes:   Addresses, sizes and configuration reset values are named here; the bench also uses literal addresses.
package memory_map_pkg;

  localparam logic [15:0] RAM_FIRST        = 16'h0060;
  localparam logic [15:0] RAM_LAST         = 16'h045F;
  localparam int          RAM_BYTES        = 1024;
  localparam logic [15:0] SP_RESET         = 16'h00FF;
  localparam int          INT_STACK_BYTES  = 5;
  localparam int          CALL_STACK_BYTES = 2;

  localparam logic [15:0] USER_FIRST       = 16'h7000;
  localparam logic [15:0] USER_LAST        = 16'hEFFF;
  localparam int          USER_BYTES       = 32768;
  localparam logic [15:0] OPTION_ADDR      = 16'hFFCF;
  localparam logic [15:0] VEC_LAST         = 16'hFFFF;
  localparam int          VEC_BYTES        = 48;
  localparam int          PAGE_BYTES       = 512;
  localparam int          PAGE_SHIFT       = 9;
  localparam logic [15:0] VEC_PAGE_FIRST   = 16'hFE00;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;

  localparam logic [15:0] VEC_RESET        = 16'hFFFE;
  localparam logic [15:0] VEC_SWI          = 16'hFFFC;
  localparam logic [15:0] VEC_SRC_BASE     = 16'hFFFC;
  localparam int          VEC_SOURCES      = 15;

  localparam logic [11:0] OFS_CONFIG_ONE   = 12'h000;
  localparam logic [11:0] OFS_CONFIG_TWO   = 12'h004;
  localparam logic [11:0] OFS_STACK_PTR    = 12'h008;
  localparam logic [11:0] OFS_FLASH_PROG   = 12'h00C;
  localparam logic [11:0] OFS_FLASH_ERASE  = 12'h010;
  localparam logic [11:0] OFS_STATUS       = 12'h014;

  localparam int CFG1_STOP_ENABLE   = 0;
  localparam int CFG1_WDOG_DISABLE  = 1;
  localparam int CFG2_USB_RST_IRQ   = 0;
  localparam int CFG2_USB_REG_DIS   = 1;
  localparam int CFG2_RC_STOP_RUN   = 2;
  localparam int CFG2_XTAL_STOP_RUN = 3;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] CFG2_RESET = 8'h00;

  // CPU register state saved on interrupt entry; the high index byte is absent.
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  ccr;
  } cpu_ctx_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] word;
  } vector_s;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PUSH = 1'b1
  } stack_state_e;

endpackage

// file: memory_map_and_config_chk.sv
// Purpose: Port assertions for the memory map and configuration block.
// Assumes: Configuration registers change only through APB writes.
// Notes:   Configuration registers are mirrored from APB writes.
module memory_map_and_config_chk
  import memory_map_pkg::*;
(
  input wire logic        pclk,                  // Clock.
  input wire logic        presetn,               // Reset.
  input wire logic [11:0] paddr,                 // Address.
  input wire logic        psel,                  // Select.
  input wire logic        penable,               // Enable.
  input wire logic        pwrite,                // Write.
  input wire logic [31:0] pwdata,                // Write data.
  input wire logic [15:0] stack_pointer,         // Stack pointer.
  input wire logic        stack_busy,            // Stacking.
  input wire logic        stk_push,              // Push.
  input wire logic        stk_pull,              // Pull.
  input wire logic        int_entry,             // Interrupt entry.
  input wire logic        call_entry,            // Call entry.
  input wire logic        software_interrupt,    // Software request.
  input wire vector_s     int_vector,            // Vector.
  input wire logic        stop_opcode,           // Stop opcode.
  input wire logic        stop_mode,             // Stop mode.
  input wire logic        illegal_opcode,        // Illegal pulse.
  input wire logic        operating_watchdog,    // Watchdog run.
  input wire logic        oscillator_run_enable, // Oscillator enable.
  input wire logic        usb_regulator_enable   // Regulator on.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cfg1_ff;
  logic [7:0] cfg2_ff;
  logic       wr;
  assign wr = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {cfg1_ff, cfg2_ff} <= {CFG1_RESET, CFG2_RESET};
    else if (wr && paddr == OFS_CONFIG_ONE)
      cfg1_ff <= pwdata[7:0];
    else if (wr && paddr == OFS_CONFIG_TWO)
      cfg2_ff <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sp_reset_a: assert property (!$past(presetn) |-> stack_pointer == SP_RESET)
    else $error("stack pointer reset");
  int_busy_a: assert property (int_entry && !stack_busy |=> stack_busy [*5] ##1 !stack_busy)
    else $error("interrupt stack length");
  int_sp_a: assert property (int_entry && !stack_busy |->
    ##6 stack_pointer == $past(stack_pointer, 6) - 16'h0005) else $error("interrupt frame size");
  call_busy_a: assert property (call_entry && !int_entry && !stack_busy
    |=> stack_busy [*2] ##1 !stack_busy) else $error("call stack length");
  push_dec_a: assert property (stk_push && !stack_busy && !int_entry && !call_entry
    |=> stack_pointer == $past(stack_pointer) - 16'h0001) else $error("push step");
  pull_inc_a: assert property (stk_pull && !stk_push && !stack_busy && !int_entry
    && !call_entry |=> stack_pointer == $past(stack_pointer) + 16'h0001) else $error("pull");
  stop_bad_a: assert property (stop_opcode && !cfg1_ff[CFG1_STOP_ENABLE] |=> illegal_opcode)
    else $error("stop not refused");
  stop_in_a: assert property (stop_opcode && cfg1_ff[CFG1_STOP_ENABLE]
    |=> stop_mode && !illegal_opcode) else $error("stop not entered");
  wdog_run_a: assert property ($past(presetn)
    |-> operating_watchdog == !$past(cfg1_ff[CFG1_WDOG_DISABLE])) else $error("watchdog run");
  osc_stop_a: assert property ($past(presetn) |-> oscillator_run_enable ==
    (!$past(stop_mode) || $past(cfg2_ff[CFG2_XTAL_STOP_RUN]))) else $error("oscillator enable");
  reg_off_a: assert property ($past(presetn)
    |-> usb_regulator_enable == !$past(cfg2_ff[CFG2_USB_REG_DIS])) else $error("regulator");
  swi_vec_a: assert property ($past(presetn) && $past(software_interrupt)
    |-> int_vector.valid && int_vector.addr == VEC_SWI) else $error("software vector");
  cover property (int_entry && !stack_busy);
  cover property (stop_mode && !oscillator_run_enable);
  cover property (software_interrupt);
endmodule
bind memory_map_and_config memory_map_and_config_chk i_memory_map_and_config_chk (.*);

// file: cpu_model.sv
// Purpose: CPU core model driving the memory port of the block.
// Assumes: One access at a time; read data is registered one cycle after the strobe.
// Notes:   Idle write data shows the inverse of the last value sent.
module cpu_model
  import memory_map_pkg::*;
(
  input  wire logic        pclk,      // Clock.
  input  wire logic [7:0]  cpu_rdata, // Read data.
  output logic      [15:0] cpu_addr,  // Address.
  output logic             cpu_rd,    // Read strobe.
  output logic             cpu_wr,    // Write strobe.
  output logic      [7:0]  cpu_wdata  // Write data.
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {cpu_addr, cpu_rd, cpu_wr, cpu_wdata} = '0;
  end
  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    cpu_addr <= a;
    cpu_wr <= w;
    cpu_rd <= !w;
    cpu_wdata <= d;
    @(posedge pclk);
    cpu_wr <= 1'h0;
    cpu_rd <= 1'h0;
    cpu_wdata <= ~d;
    @(posedge pclk);
    q = cpu_rdata;
  endtask
endmodule

// file: test_memory_map_and_config.sv
// Purpose: Self-checking bench for the memory map and configuration block.
// Assumes: APB answers through pready; memory traffic goes through the core model.
// Notes:   Flash pages are erased before they are read.
module test_memory_map_and_config
  import memory_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] cpu_addr, sp_load_value, stack_pointer, call_return;
  logic [7:0]  cpu_rdata, cpu_wdata, stk_push_data, stk_pull_data, b;
  logic        cpu_rd, cpu_wr, stk_push, stk_pull, sp_load, int_entry, call_entry, stack_busy;
  logic        software_interrupt, stop_opcode, stop_wake, illegal_opcode, stop_mode;
  logic        oscillator_run_enable, rc_clock_run, operating_watchdog, usb_regulator_enable;
  logic        usb_bus_reset, usb_irq_ack, usb_reset_irq, chip_reset_req, flash_busy;
  logic [VEC_SOURCES:1] irq_pending;
  cpu_ctx_s    int_ctx;
  vector_s     int_vector;
  int          fail_count, checks;
  memory_map_and_config i_memory_map_and_config (.*);
  cpu_model i_cpu_model (.*);
  always #5 pclk = ~pclk;
  task automatic final_report();
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang(input logic s, input logic v);
    if (s !== v)
    begin
      check(s, v);
      final_report();
    end
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n = 0;
    do
      @(posedge pclk);
    while (s !== v && ++n < 700);
    hang(s, v);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1 && ++n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    hang(pready, 1'h1);
    @(posedge pclk);
  endtask
  task automatic expect_byte(input logic [15:0] a, input logic [7:0] e);
    i_cpu_model.access(1'h0, a, 8'h00, b);
    check(b, e);
  endtask
  task automatic erase(input logic [15:0] a);
    apb(1'h1, OFS_FLASH_ERASE, {16'h0000, a});
    wait_for(flash_busy, 1'h0);
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    apb(1'h1, OFS_FLASH_PROG, {8'h00, d, a});
  endtask
  task automatic stop_cycle(input logic ill);
    stop_opcode <= 1'h1;
    @(posedge pclk);
    stop_opcode <= 1'h0;
    @(posedge pclk);
    check(illegal_opcode, ill);
    @(posedge pclk);
  endtask
  task automatic t_reset();
    check(stack_pointer, SP_RESET);
    apb(1'h0, OFS_STACK_PTR, 32'h0);
    check(q, {16'h0000, SP_RESET});
    apb(1'h0, OFS_CONFIG_TWO, 32'h0);
    check(q, 32'h0000_0000);
    apb(1'h0, 12'h018, 32'h0);
    check(err, 1'h1);
  endtask
  task automatic t_ram();
    logic [15:0] a [5] = '{16'h0060, 16'h00FF, 16'h045F, 16'h005F, 16'h0460};
    for (int i = 0; i < 5; i++)
      i_cpu_model.access(1'h1, a[i], a[i][7:0] ^ 8'hA5, b);
    for (int i = 0; i < 5; i++)
      expect_byte(a[i], (i < 3) ? (a[i][7:0] ^ 8'hA5) : 8'h00);
  endtask
  task automatic t_stack();
    logic [7:0] e [6] = '{8'hEF, 8'hBE, 8'h11, 8'h22, 8'h33, 8'h5A};
    i_cpu_model.access(1'h1, 16'h01FB, 8'h5A, b);
    sp_load <= 1'h1;
    sp_load_value <= 16'h0200;
    @(posedge pclk);
    sp_load <= 1'h0;
    int_ctx <= {16'hBEEF, 8'h11, 8'h22, 8'h33};
    int_entry <= 1'h1;
    @(posedge pclk);
    int_entry <= 1'h0;
    wait_for(stack_busy, 1'h0);
    check(stack_pointer, 16'h01FB);
    for (int i = 0; i < 6; i++)
      expect_byte(16'h0200 - 16'(i), e[i]);
    call_return <= 16'h1234;
    call_entry <= 1'h1;
    @(posedge pclk);
    call_entry <= 1'h0;
    wait_for(stack_busy, 1'h0);
    check(stack_pointer, 16'h01F9);
    expect_byte(16'h01FB, 8'h34);
    expect_byte(16'h01FA, 8'h12);
    stk_push_data <= 8'hC3;
    stk_push <= 1'h1;
    @(posedge pclk);
    stk_push <= 1'h0;
    stk_pull <= 1'h1;
    @(posedge pclk);
    stk_pull <= 1'h0;
    check(stack_pointer, 16'h01F8);
    repeat (2) @(posedge pclk);
    check(stk_pull_data, 8'hC3);
    check(stack_pointer, 16'h01F9);
  endtask
  task automatic t_flash();
    erase(16'h7200);
    prog(16'h7200, 8'h00);
    erase(16'h7000);
    prog(16'h7001, 8'h3C);
    erase(16'hEE00);
    erase(VEC_PAGE_FIRST);
    prog(16'hFFF8, 8'h12);
    prog(16'hFFF9, 8'h34);
    expect_byte(16'h7000, 8'hFF);
    expect_byte(16'h71FF, 8'hFF);
    expect_byte(16'h7200, 8'h00);
    expect_byte(16'h7001, 8'h3C);
    expect_byte(16'hEFFF, 8'hFF);
    expect_byte(16'h6FFF, 8'h00);
    expect_byte(16'hF000, 8'h00);
    expect_byte(16'hFFD0, 8'hFF);
    expect_byte(16'hFFCF, 8'hFF);
  endtask
  task automatic t_vec();
    logic [14:0] p [3] = '{15'h0012, 15'h4000, 15'h0000};
    logic [32:0] e [3] = '{{1'h1, 16'hFFF8, 16'h1234}, {1'h1, 16'hFFDE, 16'hFFFF},
                           {1'h0, 16'hFFFE, 16'hFFFF}};
    for (int i = 0; i < 3; i++)
    begin
      irq_pending <= p[i];
      repeat (2) @(posedge pclk);
      check(int_vector, e[i]);
    end
    software_interrupt <= 1'h1;
    irq_pending <= 15'h0001;
    repeat (2) @(posedge pclk);
    check(int_vector.addr, VEC_SWI);
    software_interrupt <= 1'h0;
  endtask
  task automatic t_cfg();
    apb(1'h1, OFS_CONFIG_ONE, 32'h0000_0000);
    stop_cycle(1'h1);
    check(stop_mode, 1'h0);
    apb(1'h1, OFS_CONFIG_ONE, 32'h0000_0003);
    stop_cycle(1'h0);
    check({stop_mode, operating_watchdog}, 2'h2);
    check({oscillator_run_enable, rc_clock_run}, 2'h0);
    stop_wake <= 1'h1;
    @(posedge pclk);
    stop_wake <= 1'h0;
    apb(1'h1, OFS_CONFIG_TWO, 32'h0000_000E);
    stop_cycle(1'h0);
    check({oscillator_run_enable, rc_clock_run}, 2'h3);
    check(usb_regulator_enable, 1'h0);
    stop_wake <= 1'h1;
    usb_bus_reset <= 1'h1;
    @(posedge pclk);
    stop_wake <= 1'h0;
    wait_for(chip_reset_req, 1'h1);
    check(usb_reset_irq, 1'h0);
    usb_bus_reset <= 1'h0;
    apb(1'h1, OFS_CONFIG_TWO, 32'h0000_0001);
    repeat (5) @(posedge pclk);
    usb_bus_reset <= 1'h1;
    wait_for(usb_reset_irq, 1'h1);
    usb_bus_reset <= 1'h0;
    usb_irq_ack <= 1'h1;
    @(posedge pclk);
    usb_irq_ack <= 1'h0;
    repeat (2) @(posedge pclk);
    check(usb_reset_irq, 1'h0);
    apb(1'h0, OFS_CONFIG_TWO, 32'h0);
    check(q, 32'h0000_0001);
  endtask
  initial
  begin
    pclk = 1'h0;
    presetn = 1'h0;
    fail_count = 0;
    checks = 0;
    {psel, penable, pwrite, stk_push, stk_pull, sp_load, int_entry, call_entry} = '0;
    {software_interrupt, stop_opcode, stop_wake, usb_bus_reset, usb_irq_ack} = '0;
    {paddr, pwdata, stk_push_data, sp_load_value, int_ctx, call_return, irq_pending} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_ram();
    t_stack();
    t_flash();
    t_vec();
    t_cfg();
    final_report();
  end
endmodule
